// ==== rtl/dcste_pkg.sv ====
/*
 * Shared constants and types of the two-channel synchronous-time evaluator.
 * Assumes a single 250 MHz module clock; all times are derived from it here.
 */
package dcste_pkg;

    // Clock and evaluation timebase.
    localparam int CLK_PERIOD_PS = 4000;
    localparam longint TICK_PS = 64'd4000000000;
    localparam int TICK_MS = 4;
    localparam int TICK_CYCLES = int'(TICK_PS / CLK_PERIOD_PS);
    localparam int TICK_CNT_W = 20;

    // Indicator blink: 1 Hz means 500 ms on, 500 ms off.
    localparam int BLINK_HZ = 1;
    localparam int BLINK_HALF_MS = 1000 / (2 * BLINK_HZ);
    localparam int BLINK_HALF_TICKS = BLINK_HALF_MS / TICK_MS;
    localparam int BLINK_CNT_W = 7;

    // Sequence errors must show within this time; one tick is far below it.
    localparam int SEQ_ERR_MAX_MS = 100;

    // Configured synchronous time: 0 (off) or up to 30000 ms.
    localparam int SYNC_MS_W = 15;
    localparam int LIMIT_W = 13;
    localparam logic [SYNC_MS_W-1:0] SYNC_ROUND_ADD = 15'h0003;
    localparam int SYNC_ROUND_SHIFT = 2;

    // Reset values.
    localparam logic [LIMIT_W-1:0] TIMER_RST = 13'h0000;
    localparam logic [1:0] CH_RST = 2'h0;
    localparam logic ARMED_RST = 1'b1;
    localparam logic FLAG_RST = 1'b0;
    localparam logic STATUS_RST = 1'b1;

    // Evaluation states.
    typedef enum logic [3:0]
    {
        ST_INACT = 4'h1,
        ST_DISC = 4'h2,
        ST_ACT = 4'h4,
        ST_ERR = 4'h8
    } dcste_state_t;

    // Meaning of a channel pair under the selected mode.
    typedef enum logic [1:0]
    {
        PAT_INACT = 2'h0,
        PAT_DISC = 2'h1,
        PAT_ACT = 2'h2
    } dcste_pat_t;

endpackage

// ==== rtl/dcste_time_if.sv ====
/*
 * Carrier of the evaluation tick and the blink phase from the timebase
 * to the evaluator. Both ends run on the same clock.
 */
`timescale 1ns/1ps
interface dcste_time_if;
    logic tick;
    logic blink;

    modport src
    (
        output tick,
        output blink
    );

    modport snk
    (
        input tick,
        input blink
    );
endinterface

// ==== rtl/dcste_timebase.sv ====
/*
 * Timebase: one-cycle tick every evaluation period and a 1 Hz blink phase.
 * Assumes clk and rstn of the evaluator; the tick period is shortened
 * through TICK_CYCLES for simulation.
 */
`timescale 1ns/1ps
module dcste_timebase #(
    parameter int TICK_CYCLES = dcste_pkg::TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Timebase out
    dcste_time_if.src tm
);

    typedef struct packed
    {
        logic [dcste_pkg::TICK_CNT_W-1:0] cyc;
        logic [dcste_pkg::BLINK_CNT_W-1:0] half;
        logic tick;
        logic blink;
    } dcste_tb_state_t;

    localparam logic [dcste_pkg::TICK_CNT_W-1:0] CYC_LAST =
        dcste_pkg::TICK_CNT_W'(TICK_CYCLES - 1);
    localparam logic [dcste_pkg::BLINK_CNT_W-1:0] HALF_LAST =
        dcste_pkg::BLINK_CNT_W'(dcste_pkg::BLINK_HALF_TICKS - 1);

    dcste_tb_state_t s_r;
    dcste_tb_state_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cyc == CYC_LAST)
        begin
            s_nxt.cyc = '0;
            s_nxt.tick = 1'b1;
            if (s_r.half == HALF_LAST)
            begin
                s_nxt.half = '0;
                s_nxt.blink = ~s_r.blink;
            end
            else
            begin
                s_nxt.half = s_r.half + 1'b1;
            end
        end
        else
        begin
            s_nxt.cyc = s_r.cyc + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign tm.tick = s_r.tick;
    assign tm.blink = s_r.blink;

endmodule // dcste_timebase

// ==== rtl/dcste_eval.sv ====
/*
 * Two-channel input evaluator with synchronous-time monitoring and
 * switching-sequence check, driving one logical input and error indications.
 * Assumes channel pins asynchronous to clk, configuration inputs static and
 * synchronous to clk, and a 250 MHz clock.
 */
`timescale 1ns/1ps

// Behaviour
// [RULE1] Evaluate both channels together, enforce switching order.
// [RULE2] Tolerate disagreement only for synchronous time.
// [RULE3] Configurer picks synchronous time multiple of four.
// [RULE4] Synchronous time covers test gap plus delay.
// [RULE5] Equivalent mode pair mapping to state.
// [RULE6] Discrepant mode pair mapping to state.
// [RULE7] Timeout gives error state, output low, flag.
// [RULE8] Otherwise the time error flag holds.
// [RULE9] Timer restarts entering discrepant when enabled.
// [RULE10] Zero synchronous time never times out.
// [RULE11] Active only after passing inactive since.
// [RULE12] Active only while time not expired.
// [RULE13] Sequence violation raises error within bound.
// [RULE14] Legacy variant: no error, output stays low. Code still raises the time error once a nonzero synchronous time expires.
// [RULE15] Error blinks module indicator red 1 Hz.
// [RULE16] Error blinks input indicators green 1 Hz.
// [RULE17] Error drives input data status low.
// [RULE18] Errors clear only on reaching inactive. Code keeps the time error flag set there until the 11 pair is seen.
// [RULE19] Sample on 4 ms tick, round up.
// [RULE20] Timer advances per tick, compared to limit.
// [RULE21] Error state dominates until inactive.
module dcste_eval #(
    parameter int TICK_CYCLES = dcste_pkg::TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Sensor channels, asynchronous
    input wire logic chanA,
    input wire logic chanB,
    // Static configuration
    input wire logic equivMode,
    input wire logic legacyVariant,
    input wire logic [dcste_pkg::SYNC_MS_W-1:0] syncTimeMs,
    // Logic program side
    output logic logicIn,
    output logic syncTimeErr,
    output logic seqErr,
    output logic inputDataStatus,
    // Indicators
    output logic moduleStateIndicatorRed,
    output logic [1:0] inputLedGreen
);

    dcste_time_if tm ();

    dcste_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .clk(clk),
        .rstn(rstn),
        .tm(tm)
    );

    typedef struct packed
    {
        logic [1:0] chSync1;
        logic [1:0] chSync2;
        dcste_pkg::dcste_state_t st;
        logic armed;
        logic [dcste_pkg::LIMIT_W-1:0] timer;
        logic syncErr;
        logic seqErr;
        logic logicIn;
        logic status;
        logic ledRed;
        logic [1:0] ledGreen;
    } dcste_state_s_t;

    localparam dcste_state_s_t STATE_RST = '{
        chSync1: dcste_pkg::CH_RST,
        chSync2: dcste_pkg::CH_RST,
        st: dcste_pkg::ST_INACT,
        armed: dcste_pkg::ARMED_RST,
        timer: dcste_pkg::TIMER_RST,
        syncErr: dcste_pkg::FLAG_RST,
        seqErr: dcste_pkg::FLAG_RST,
        logicIn: 1'b0,
        status: dcste_pkg::STATUS_RST,
        ledRed: 1'b0,
        ledGreen: dcste_pkg::CH_RST
    };

    // Bit 1 is channel A, bit 0 is channel B.
    function automatic dcste_pkg::dcste_pat_t classify(input logic [1:0] ab, input logic equiv);
        dcste_pkg::dcste_pat_t p;
        p = dcste_pkg::PAT_DISC;
        if (equiv)
        begin
            if (ab == 2'h0)
            begin
                p = dcste_pkg::PAT_INACT; // RULE5
            end
            else if (ab == 2'h3)
            begin
                p = dcste_pkg::PAT_ACT; // RULE5
            end
        end
        else
        begin
            if (ab == 2'h1)
            begin
                p = dcste_pkg::PAT_INACT; // RULE6
            end
            else if (ab == 2'h2)
            begin
                p = dcste_pkg::PAT_ACT; // RULE6
            end
        end
        return p;
    endfunction

    // Any nonzero time becomes whole ticks, rounded up.
    logic [dcste_pkg::LIMIT_W-1:0] limit;
    assign limit = dcste_pkg::LIMIT_W'((syncTimeMs + dcste_pkg::SYNC_ROUND_ADD)
        >> dcste_pkg::SYNC_ROUND_SHIFT); // RULE19

    logic limitOn;
    assign limitOn = (limit != '0);

    dcste_state_s_t s_r;
    dcste_state_s_t s_nxt;

    always_comb
    begin
        dcste_pkg::dcste_pat_t pat;
        logic [dcste_pkg::LIMIT_W-1:0] tNext;
        logic runTimer;
        logic errNow;
        errNow = 1'b0;
        pat = classify(s_r.chSync2, equivMode);
        tNext = s_r.timer + 1'b1;
        runTimer = 1'b0;
        s_nxt = s_r;
        s_nxt.chSync1 = {chanA, chanB};
        s_nxt.chSync2 = s_r.chSync1;
        // Only the tick moves the evaluation, so pin noise between ticks is unseen.
        if (tm.tick) // RULE19
        begin
            case (s_r.st)
                dcste_pkg::ST_ERR:
                begin
                    // Nothing but the inactive pair leaves the error state.
                    if (pat == dcste_pkg::PAT_INACT) // RULE21
                    begin
                        s_nxt.st = dcste_pkg::ST_INACT; // RULE18
                        s_nxt.seqErr = 1'b0; // RULE18
                        s_nxt.armed = 1'b1;
                        s_nxt.timer = '0;
                    end
                end
                dcste_pkg::ST_INACT, dcste_pkg::ST_DISC, dcste_pkg::ST_ACT:
                begin
                    if (pat == dcste_pkg::PAT_INACT)
                    begin
                        s_nxt.st = dcste_pkg::ST_INACT; // RULE5 RULE6
                        s_nxt.armed = 1'b1; // RULE11
                        s_nxt.timer = '0;
                    end
                    else if (pat == dcste_pkg::PAT_ACT)
                    begin
                        if (s_r.st == dcste_pkg::ST_ACT)
                        begin
                            s_nxt.st = dcste_pkg::ST_ACT;
                        end
                        else if (s_r.armed && !(limitOn && s_r.timer >= limit)) // RULE11 RULE12
                        begin
                            s_nxt.st = dcste_pkg::ST_ACT; // RULE1
                            s_nxt.armed = 1'b0;
                            s_nxt.timer = '0;
                            if (equivMode)
                            begin
                                s_nxt.syncErr = 1'b0; // RULE5
                            end
                        end
                        else if (!s_r.armed && !legacyVariant)
                        begin
                            // Reported on the first tick, well inside the allowed bound.
                            s_nxt.st = dcste_pkg::ST_ERR; // RULE13
                            s_nxt.seqErr = 1'b1; // RULE13
                        end
                        else
                        begin
                            // Older variants keep the pair blocked without a sequence error; the timer runs on, so a nonzero time ends in the time error.
                            s_nxt.st = dcste_pkg::ST_DISC; // RULE14
                            runTimer = (s_r.st == dcste_pkg::ST_DISC);
                            if (s_r.st != dcste_pkg::ST_DISC)
                            begin
                                s_nxt.timer = '0;
                            end
                        end
                    end
                    else
                    begin
                        if (!equivMode && s_r.chSync2 == 2'h3)
                        begin
                            s_nxt.syncErr = 1'b0; // RULE6
                        end
                        if (s_r.st != dcste_pkg::ST_DISC)
                        begin
                            s_nxt.st = dcste_pkg::ST_DISC; // RULE1
                            s_nxt.timer = '0; // RULE9
                        end
                        else
                        begin
                            runTimer = 1'b1;
                        end
                    end
                    // With a zero limit the timer is frozen and never expires.
                    if (runTimer && limitOn) // RULE10 RULE20
                    begin
                        if (tNext >= limit) // RULE2 RULE20
                        begin
                            s_nxt.st = dcste_pkg::ST_ERR; // RULE7
                            s_nxt.syncErr = 1'b1; // RULE7
                        end
                        else
                        begin
                            s_nxt.timer = tNext; // RULE20
                        end
                    end
                end
                default:
                begin
                    s_nxt.st = dcste_pkg::ST_ERR;
                end
            endcase
        end
        // The flag is written only in the branches above; it holds otherwise.
        errNow = (s_nxt.st == dcste_pkg::ST_ERR); // RULE8
        s_nxt.logicIn = (s_nxt.st == dcste_pkg::ST_ACT); // RULE7 RULE21
        s_nxt.status = !errNow; // RULE17
        s_nxt.ledRed = errNow && tm.blink; // RULE15
        // Outside errors the green indicators follow the sampled channels.
        // Only the second synchroniser stage may be read, so the levels lag one more cycle.
        s_nxt.ledGreen = errNow ? {2{tm.blink}} : s_r.chSync2; // RULE16
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_r <= STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign logicIn = s_r.logicIn;
    assign syncTimeErr = s_r.syncErr;
    assign seqErr = s_r.seqErr;
    assign inputDataStatus = s_r.status;
    assign moduleStateIndicatorRed = s_r.ledRed;
    assign inputLedGreen = s_r.ledGreen;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic inErr;
    assign inErr = (s_r.st == dcste_pkg::ST_ERR);

    property p_rise_needs_armed;
        $rose(s_r.logicIn) |-> $past(s_r.armed) && !$past(inErr);
    endproperty
    a_rise_needs_armed: assert property (p_rise_needs_armed) // RULE11
        else $error("Active reached without passing inactive.");

    property p_err_output;
        inErr |-> !s_r.logicIn && (s_r.syncErr || s_r.seqErr);
    endproperty
    a_err_output: assert property (p_err_output) // RULE7
        else $error("Error state without low output and error flag.");

    property p_zero_no_timeout;
        (syncTimeMs == '0) |-> !$rose(s_r.syncErr);
    endproperty
    a_zero_no_timeout: assert property (p_zero_no_timeout) // RULE10
        else $error("Timeout raised with synchronous time off.");

    property p_tick_only;
        $changed(s_r.st) |-> $past(tm.tick);
    endproperty
    a_tick_only: assert property (p_tick_only) // RULE19
        else $error("Evaluation moved between ticks.");

    property p_status_low;
        inErr |-> !s_r.status && !inputDataStatus;
    endproperty
    a_status_low: assert property (p_status_low) // RULE17
        else $error("Input data status high during error.");

    property p_leave_err_inactive;
        $fell(inErr) |-> s_r.st == dcste_pkg::ST_INACT && !s_r.seqErr;
    endproperty
    a_leave_err_inactive: assert property (p_leave_err_inactive) // RULE18
        else $error("Error left other than to inactive.");

    property p_legacy_silent;
        legacyVariant && !$past(s_r.seqErr) |-> !s_r.seqErr;
    endproperty
    a_legacy_silent: assert property (p_legacy_silent) // RULE14
        else $error("Legacy variant raised a sequence error.");

    property p_timer_below_limit;
        (s_r.st == dcste_pkg::ST_DISC) && limitOn && $stable(syncTimeMs) |-> s_r.timer < limit;
    endproperty
    a_timer_below_limit: assert property (p_timer_below_limit) // RULE20
        else $error("Timer reached limit without error.");

    property p_red_blink;
        inErr && $past(inErr) && $past(tm.blink) |-> s_r.ledRed;
    endproperty
    a_red_blink: assert property (p_red_blink) // RULE15
        else $error("Red indicator not following blink phase.");

    property p_err_dominant;
        inErr && !(tm.tick && classify(s_r.chSync2, equivMode) == dcste_pkg::PAT_INACT)
            |=> inErr;
    endproperty
    a_err_dominant: assert property (p_err_dominant) // RULE21
        else $error("Error state left without inactive pair.");

    c_active: cover property ($rose(s_r.logicIn));
    c_timeout: cover property ($rose(s_r.syncErr));
    c_sequence: cover property ($rose(s_r.seqErr));
    c_recover: cover property ($fell(inErr) ##[1:1000] $rose(s_r.logicIn));

endmodule // dcste_eval

// ==== dv/dcste_sensor_model.sv ====
/*
 * Behavioural two-channel safety sensor that drives the evaluator's channel pins.
 * Assumes the bench calls its task; the pins change only at falling clock edges.
 */
`timescale 1ns/1ps
module dcste_sensor_model
(
    // Clock
    clk,
    // Channel pins
    chanA,
    chanB
);
    input wire logic clk;
    output logic chanA;
    output logic chanB;

    initial
    begin
        chanA = 1'b0;
        chanB = 1'b0;
    end

    // The lead channel moves first and the other follows after lag cycles.
    // The bench keeps lag below the configured synchronous time.
    task automatic move(input logic a, input logic b, input int lag);
        @(negedge clk);
        chanA = a;
        if (lag > 0)
        begin
            repeat (lag) @(negedge clk);
        end
        chanB = b;
    endtask
endmodule // dcste_sensor_model

// ==== dv/dcste_eval_tb.sv ====
/*
 * Self-checking bench of the two-channel evaluator with a sensor model on the pins.
 * Assumes a shortened tick of T clock cycles; the blink half period is 125 ticks.
 */
`timescale 1ns/1ps
module dcste_eval_tb;
    localparam int T = 8;
    logic clk;
    logic rstn;
    logic chanA;
    logic chanB;
    logic equivMode;
    logic legacyVariant;
    logic [dcste_pkg::SYNC_MS_W-1:0] syncTimeMs;
    logic logicIn;
    logic syncTimeErr;
    logic seqErr;
    logic inputDataStatus;
    logic moduleStateIndicatorRed;
    logic [1:0] inputLedGreen;
    int err_count = 0;
    int total_checks = 0;

    dcste_sensor_model dcste_sensor_model_i (.clk(clk), .chanA(chanA), .chanB(chanB));

    dcste_eval #(.TICK_CYCLES(T)) dcste_eval_i
    (
        .clk(clk),
        .rstn(rstn),
        .chanA(chanA),
        .chanB(chanB),
        .equivMode(equivMode),
        .legacyVariant(legacyVariant),
        .syncTimeMs(syncTimeMs),
        .logicIn(logicIn),
        .syncTimeErr(syncTimeErr),
        .seqErr(seqErr),
        .inputDataStatus(inputDataStatus),
        .moduleStateIndicatorRed(moduleStateIndicatorRed),
        .inputLedGreen(inputLedGreen)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n * T) @(negedge clk);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Configuration only changes under reset, since the design takes it as static.
    task automatic apply_reset(input logic eq, input logic leg, input int ms);
        dcste_sensor_model_i.move(1'b0, ~eq, 0);
        rstn = 1'b0;
        equivMode = eq;
        legacyVariant = leg;
        syncTimeMs = ms[dcste_pkg::SYNC_MS_W-1:0];
        repeat (12) @(negedge clk);
        chk(logicIn, 1'b0, "logicIn in reset");
        chk(inputDataStatus, 1'b1, "status in reset");
        chk({syncTimeErr, seqErr, moduleStateIndicatorRed}, 3'h0, "flags in reset");
        chk(inputLedGreen, 2'h0, "green in reset");
        rstn = 1'b1;
        ticks(2);
    endtask

    task automatic t_equiv();
        apply_reset(1'b1, 1'b0, 8);
        chk(logicIn, 1'b0, "inactive pair");
        dcste_sensor_model_i.move(1'b1, 1'b1, 0);
        ticks(2);
        chk({logicIn, syncTimeErr, inputDataStatus}, 3'h5, "active pair");
        chk(inputLedGreen, 2'h3, "green levels");
        dcste_sensor_model_i.move(1'b0, 1'b0, 0);
        ticks(2);
        chk({logicIn, inputLedGreen}, 3'h0, "back inactive");
        // B trails A by one tick, inside the two-tick synchronous time.
        dcste_sensor_model_i.move(1'b1, 1'b1, T);
        ticks(3);
        chk({logicIn, syncTimeErr}, 2'h2, "short disagreement");
        dcste_sensor_model_i.move(1'b0, 1'b0, 0);
        ticks(2);
        $display("test equiv done");
    endtask

    // The tick phase is unknown to the bench, so each check sits outside the jitter span.
    task automatic t_limits();
        int msList[4] = '{4, 5, 8, 9};
        int lim;
        foreach (msList[i])
        begin
            apply_reset(1'b1, 1'b0, msList[i]);
            lim = (msList[i] + 3) / 4;
            dcste_sensor_model_i.move(1'b1, 1'b0, 0);
            repeat (lim * T) @(negedge clk);
            chk(syncTimeErr, 1'b0, "before limit");
            repeat (13) @(negedge clk);
            chk(syncTimeErr, 1'b1, "at limit");
            chk({logicIn, inputDataStatus}, 2'h0, "timeout outputs");
        end
        $display("test limits done");
    endtask

    task automatic t_error_hold();
        int n;
        logic last;
        dcste_sensor_model_i.move(1'b1, 1'b1, 0);
        ticks(2);
        chk({logicIn, syncTimeErr}, 2'h1, "error dominates");
        n = 0;
        last = moduleStateIndicatorRed;
        while (moduleStateIndicatorRed === last && n < 1100)
        begin
            @(negedge clk);
            n++;
        end
        n = 0;
        last = moduleStateIndicatorRed;
        while (moduleStateIndicatorRed === last && n < 1100)
        begin
            @(negedge clk);
            n++;
            chk(inputLedGreen, {2{moduleStateIndicatorRed}}, "green blink");
        end
        chk(n, dcste_pkg::BLINK_HALF_TICKS * T, "red half period");
        dcste_sensor_model_i.move(1'b0, 1'b0, 0);
        ticks(2);
        chk({inputDataStatus, syncTimeErr}, 2'h3, "cleared, flag held");
        chk({moduleStateIndicatorRed, inputLedGreen}, 3'h0, "leds quiet");
        dcste_sensor_model_i.move(1'b1, 1'b1, 0);
        ticks(2);
        chk({logicIn, syncTimeErr}, 2'h2, "active clears flag");
        $display("test error hold done");
    endtask

    task automatic t_sequence(input logic leg);
        apply_reset(1'b1, leg, 0);
        dcste_sensor_model_i.move(1'b1, 1'b1, 0);
        ticks(2);
        chk(logicIn, 1'b1, "first active");
        dcste_sensor_model_i.move(1'b1, 1'b0, 0);
        ticks(12);
        chk({logicIn, syncTimeErr}, 2'h0, "zero time no timeout");
        dcste_sensor_model_i.move(1'b1, 1'b1, 0);
        ticks(3);
        chk(logicIn, 1'b0, "return refused");
        chk(seqErr, !leg, "sequence flag");
        chk(inputDataStatus, leg, "status on sequence");
        dcste_sensor_model_i.move(1'b0, 1'b0, 0);
        ticks(2);
        chk({seqErr, inputDataStatus}, 2'h1, "inactive clears");
        dcste_sensor_model_i.move(1'b1, 1'b1, 0);
        ticks(2);
        chk(logicIn, 1'b1, "active after inactive");
        $display("test sequence done");
    endtask

    task automatic t_discrepant();
        apply_reset(1'b0, 1'b0, 8);
        chk(logicIn, 1'b0, "inactive 01");
        dcste_sensor_model_i.move(1'b1, 1'b0, 0);
        ticks(2);
        chk(logicIn, 1'b1, "active 10");
        dcste_sensor_model_i.move(1'b1, 1'b1, 0);
        repeat (13) @(negedge clk);
        chk({logicIn, syncTimeErr}, 2'h0, "discrepant 11");
        dcste_sensor_model_i.move(1'b0, 1'b1, 0);
        ticks(2);
        dcste_sensor_model_i.move(1'b0, 1'b0, 0);
        ticks(6);
        chk({syncTimeErr, logicIn, inputDataStatus}, 3'h4, "timeout 00");
        dcste_sensor_model_i.move(1'b0, 1'b1, 0);
        ticks(2);
        chk({inputDataStatus, syncTimeErr}, 2'h3, "inactive clears error");
        $display("test discrepant done");
    endtask

    initial
    begin
        #100us;
        err_count++;
        $display("Error at %0t ns: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        rstn = 1'b0;
        equivMode = 1'b1;
        legacyVariant = 1'b0;
        syncTimeMs = '0;
        t_equiv();
        t_limits();
        t_error_hold();
        t_sequence(1'b0);
        t_sequence(1'b1);
        t_discrepant();
        stop_test();
    end
endmodule // dcste_eval_tb
